// ---- hw/lo1_pkg.sv ----
// constants for the channel-one loop event status bank
// assumes an 8-bit register port with 16-bit register addresses
package lo1_pkg;
   localparam int ADDR_W   = 16;
   localparam int DATA_W   = 8;
   localparam int NUM_REGS = 5;
   localparam int IDX_W    = 3;

   // register addresses
   localparam logic [15:0] REG_LOCK    = 16'h3015;
   localparam logic [15:0] REG_STATE   = 16'h3016;
   localparam logic [15:0] REG_ACQ     = 16'h3017;
   localparam logic [15:0] REG_PROFILE = 16'h3018;
   localparam logic [15:0] REG_ANALOG  = 16'h3019;

   // bank index of each register, used by the clear port
   localparam logic [2:0] IDX_LOCK    = 3'h0;
   localparam logic [2:0] IDX_STATE   = 3'h1;
   localparam logic [2:0] IDX_ACQ     = 3'h2;
   localparam logic [2:0] IDX_PROFILE = 3'h3;
   localparam logic [2:0] IDX_ANALOG  = 3'h4;

   localparam logic [7:0] EV_RESET = 8'h00;
   localparam logic [7:0] RD_NONE  = 8'h00;

   // implemented bits; the rest are reserved and read zero
   localparam logic [7:0] MASK_LOCK    = 8'hFF;
   localparam logic [7:0] MASK_STATE   = 8'hFD;
   localparam logic [7:0] MASK_ACQ     = 8'h1C;
   localparam logic [7:0] MASK_PROFILE = 8'h3F;
   localparam logic [7:0] MASK_ANALOG  = 8'h1F;

   // lock event bits
   localparam int LK_CLAMP_OFF    = 7;
   localparam int LK_CLAMP_ON     = 6;
   localparam int LK_SLEW_OFF     = 5;
   localparam int LK_SLEW_ON      = 4;
   localparam int LK_FREQ_UNLOCK  = 3;
   localparam int LK_FREQ_LOCK    = 2;
   localparam int LK_PHASE_UNLOCK = 1;
   localparam int LK_PHASE_LOCK   = 0;

   // state event bits
   localparam int ST_REF_SWITCH  = 7;
   localparam int ST_FREERUN     = 6;
   localparam int ST_HOLDOVER    = 5;
   localparam int ST_HITLESS_IN  = 4;
   localparam int ST_HITLESS_OUT = 3;
   localparam int ST_HISTORY     = 2;
   localparam int ST_PHASE_STEP  = 0;

   // acquisition event bits
   localparam int AQ_RESYNC     = 4;
   localparam int AQ_FAST_DONE  = 3;
   localparam int AQ_FAST_START = 2;

   // profile event bits
   localparam int PF_LSB   = 0;
   localparam int PF_COUNT = 6;

   // analog loop event bits
   localparam int AN_DIST_SYNC = 4;
   localparam int AN_UNLOCK    = 3;
   localparam int AN_LOCK      = 2;
   localparam int AN_CAL_DONE  = 1;
   localparam int AN_CAL_START = 0;

   // positions of the watched levels in the level vector
   localparam int LV_CLAMP   = 0;
   localparam int LV_SLEW    = 1;
   localparam int LV_FREQ    = 2;
   localparam int LV_PHASE   = 3;
   localparam int LV_HITLESS = 4;
   localparam int LV_ALOCK   = 5;
   localparam int LV_CAL     = 6;
   localparam int LV_COUNT   = 7;
endpackage

// ---- hw/lo1_evt_if.sv ----
// carrier between the bank control logic and one sticky event byte
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface lo1_evt_if;
   logic [7:0] set;
   logic [7:0] clr;
   logic [7:0] keep;
   logic [7:0] q;
   modport bank (input set, input clr, input keep, output q);
   modport ctrl (output set, output clr, output keep, input q);
endinterface

// ---- hw/lo1_event_byte.sv ----
// one sticky 8-bit event register
// assumes set and clear are produced on the same clock
`timescale 1ns/1ns
module lo1_event_byte (
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_resetn,
   // event carrier
   lo1_evt_if.bank   evt
);
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         evt.q <= lo1_pkg::EV_RESET;
      end else begin
         evt.q <= ((evt.q & ~evt.clr) | evt.set) & evt.keep;
      end
   end
endmodule

// ---- hw/lo1_status_bank.sv ----
// channel-one loop event status bank: five read-only sticky registers
// assumes event sources and clear logic share i_clk; levels are clean
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ns
module lo1_status_bank (
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   // register port
   input  wire logic [15:0] i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [7:0]  o_rdata,
   // external clear mechanism
   input  wire logic        i_clear_stb,
   input  wire logic [2:0]  i_clear_index,
   input  wire logic [7:0]  i_clear_mask,
   // live levels from the digital loop
   input  wire logic        i_clamp_active,
   input  wire logic        i_slew_active,
   input  wire logic        i_freq_locked,
   input  wire logic        i_phase_locked,
   input  wire logic        i_hitless_active,
   // one-cycle event pulses from the digital loop
   input  wire logic        i_ref_switch,
   input  wire logic        i_freerun_entered,
   input  wire logic        i_holdover_entered,
   input  wire logic        i_history_update,
   input  wire logic        i_phase_step,
   input  wire logic        i_divider_resync,
   input  wire logic        i_fast_acq_start,
   input  wire logic        i_fast_acq_done,
   input  wire logic [5:0]  i_profile_active,
   input  wire logic        i_dist_sync,
   // live levels from the analog loop
   input  wire logic        i_analog_locked,
   input  wire logic        i_cal_busy
);
   localparam int LVN = lo1_pkg::LV_COUNT;

   lo1_evt_if ev [lo1_pkg::NUM_REGS] ();

   logic [LVN-1:0] lvl_now;
   logic [LVN-1:0] lvl_prev_reg;
   logic           armed_reg;
   logic [LVN-1:0] rise;
   logic [LVN-1:0] fall;
   logic [7:0]     rdata_reg;
   logic [7:0]     rdata_next;

   // detect a transition of one watched level
   function automatic logic went(input logic armed, input logic from, input logic to);
      return armed & from & to;
   endfunction

   // bank index for an address, all ones when unmapped
   function automatic logic [2:0] reg_index(input logic [15:0] addr);
      logic [2:0] idx;
      idx = 3'h7;
      unique case (addr)
         lo1_pkg::REG_LOCK:    idx = lo1_pkg::IDX_LOCK;
         lo1_pkg::REG_STATE:   idx = lo1_pkg::IDX_STATE;
         lo1_pkg::REG_ACQ:     idx = lo1_pkg::IDX_ACQ;
         lo1_pkg::REG_PROFILE: idx = lo1_pkg::IDX_PROFILE;
         lo1_pkg::REG_ANALOG:  idx = lo1_pkg::IDX_ANALOG;
         default:              idx = 3'h7;
      endcase
      return idx;
   endfunction

   // clear mask for one bank index, zero unless the strobe selects it
   function automatic logic [7:0] clr_for(input logic stb, input logic [2:0] sel, input logic [7:0] mask,
                                          input logic [2:0] idx);
      return (stb && sel == idx) ? mask : 8'h00;
   endfunction

   genvar g;
   generate
      for (g = 0; g < lo1_pkg::NUM_REGS; g++) begin : g_bank
         lo1_event_byte u_byte (
            .i_clk    (i_clk),
            .i_resetn (i_resetn),
            .evt      (ev[g])
         );
      end
   endgenerate

   always_comb begin
      lvl_now                       = '0;
      lvl_now[lo1_pkg::LV_CLAMP]   = i_clamp_active;
      lvl_now[lo1_pkg::LV_SLEW]    = i_slew_active;
      lvl_now[lo1_pkg::LV_FREQ]    = i_freq_locked;
      lvl_now[lo1_pkg::LV_PHASE]   = i_phase_locked;
      lvl_now[lo1_pkg::LV_HITLESS] = i_hitless_active;
      lvl_now[lo1_pkg::LV_ALOCK]   = i_analog_locked;
      lvl_now[lo1_pkg::LV_CAL]     = i_cal_busy;
   end

   // levels present at reset release are a baseline, not an event
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         armed_reg    <= 1'b0;
         lvl_prev_reg <= '0;
      end else begin
         armed_reg    <= 1'b1;
         lvl_prev_reg <= lvl_now;
      end
   end

   always_comb begin
      for (int i = 0; i < LVN; i++) begin
         rise[i] = went(armed_reg, ~lvl_prev_reg[i], lvl_now[i]);
         fall[i] = went(armed_reg, lvl_prev_reg[i], ~lvl_now[i]);
      end
   end

   // lock register sources
   always_comb begin
      ev[0].keep = lo1_pkg::MASK_LOCK;
      ev[0].set  = '0;
      ev[0].set[lo1_pkg::LK_CLAMP_OFF]    = fall[lo1_pkg::LV_CLAMP];
      ev[0].set[lo1_pkg::LK_CLAMP_ON]     = rise[lo1_pkg::LV_CLAMP];
      ev[0].set[lo1_pkg::LK_SLEW_OFF]     = fall[lo1_pkg::LV_SLEW];
      ev[0].set[lo1_pkg::LK_SLEW_ON]      = rise[lo1_pkg::LV_SLEW];
      ev[0].set[lo1_pkg::LK_FREQ_UNLOCK]  = fall[lo1_pkg::LV_FREQ];
      ev[0].set[lo1_pkg::LK_FREQ_LOCK]    = rise[lo1_pkg::LV_FREQ];
      ev[0].set[lo1_pkg::LK_PHASE_UNLOCK] = fall[lo1_pkg::LV_PHASE];
      ev[0].set[lo1_pkg::LK_PHASE_LOCK]   = rise[lo1_pkg::LV_PHASE];
   end

   // state register sources
   always_comb begin
      ev[1].keep = lo1_pkg::MASK_STATE;
      ev[1].set  = '0;
      ev[1].set[lo1_pkg::ST_REF_SWITCH]  = i_ref_switch;
      ev[1].set[lo1_pkg::ST_FREERUN]     = i_freerun_entered;
      ev[1].set[lo1_pkg::ST_HOLDOVER]    = i_holdover_entered;
      ev[1].set[lo1_pkg::ST_HITLESS_IN]  = rise[lo1_pkg::LV_HITLESS];
      ev[1].set[lo1_pkg::ST_HITLESS_OUT] = fall[lo1_pkg::LV_HITLESS];
      ev[1].set[lo1_pkg::ST_HISTORY]     = i_history_update;
      ev[1].set[lo1_pkg::ST_PHASE_STEP]  = i_phase_step;
   end

   // acquisition register sources
   always_comb begin
      ev[2].keep = lo1_pkg::MASK_ACQ;
      ev[2].set  = '0;
      ev[2].set[lo1_pkg::AQ_RESYNC]     = i_divider_resync;
      ev[2].set[lo1_pkg::AQ_FAST_START] = i_fast_acq_start;
      ev[2].set[lo1_pkg::AQ_FAST_DONE]  = i_fast_acq_done;
   end

   // profile register sources
   always_comb begin
      ev[3].keep = lo1_pkg::MASK_PROFILE;
      ev[3].set  = '0;
      ev[3].set[lo1_pkg::PF_LSB +: lo1_pkg::PF_COUNT] = i_profile_active;
   end

   // analog loop register sources
   always_comb begin
      ev[4].keep = lo1_pkg::MASK_ANALOG;
      ev[4].set  = '0;
      ev[4].set[lo1_pkg::AN_DIST_SYNC] = i_dist_sync;
      ev[4].set[lo1_pkg::AN_UNLOCK]    = fall[lo1_pkg::LV_ALOCK];
      ev[4].set[lo1_pkg::AN_LOCK]      = rise[lo1_pkg::LV_ALOCK];
      ev[4].set[lo1_pkg::AN_CAL_START] = rise[lo1_pkg::LV_CAL];
      ev[4].set[lo1_pkg::AN_CAL_DONE]  = fall[lo1_pkg::LV_CAL];
   end

   // clears come only from the external clear port
   always_comb begin
      ev[0].clr = clr_for(i_clear_stb, i_clear_index, i_clear_mask, lo1_pkg::IDX_LOCK);
      ev[1].clr = clr_for(i_clear_stb, i_clear_index, i_clear_mask, lo1_pkg::IDX_STATE);
      ev[2].clr = clr_for(i_clear_stb, i_clear_index, i_clear_mask, lo1_pkg::IDX_ACQ);
      ev[3].clr = clr_for(i_clear_stb, i_clear_index, i_clear_mask, lo1_pkg::IDX_PROFILE);
      ev[4].clr = clr_for(i_clear_stb, i_clear_index, i_clear_mask, lo1_pkg::IDX_ANALOG);
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      rdata_next = lo1_pkg::RD_NONE;
      if (i_rd) begin
         unique case (reg_index(i_addr))
            lo1_pkg::IDX_LOCK:    rdata_next = ev[0].q;
            lo1_pkg::IDX_STATE:   rdata_next = ev[1].q;
            lo1_pkg::IDX_ACQ:     rdata_next = ev[2].q;
            lo1_pkg::IDX_PROFILE: rdata_next = ev[3].q;
            lo1_pkg::IDX_ANALOG:  rdata_next = ev[4].q;
            default:              rdata_next = lo1_pkg::RD_NONE;
         endcase
      end
   end

   // writes never reach the bank; data valid one cycle
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         rdata_reg <= lo1_pkg::RD_NONE;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign o_rdata = rdata_reg;
endmodule

// ---- bench/lo1_status_bank_sva.sv ----
// checker for the channel-one loop event bank: read port and sticky bits
// assumes it is bound to lo1_status_bank and sees only its ports
`timescale 1ns/1ns
module lo1_status_bank_sva (
   // clock and reset
   input wire logic        i_clk,
   input wire logic        i_resetn,
   // register port
   input wire logic [15:0] i_addr,
   input wire logic        i_rd,
   input wire logic [7:0]  o_rdata,
   // event sources and clear
   input wire logic        i_clear_stb,
   input wire logic        i_ref_switch,
   input wire logic [5:0]  i_profile_active,
   input wire logic        i_dist_sync
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   idle_read_zero_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data not zero outside a read");
   unmapped_zero_a: assert property (i_rd && (i_addr < 16'h3015 || i_addr > 16'h3019) |=> o_rdata == 8'h00)
      else $error("unmapped address read not zero");
   state_resv_a: assert property (i_rd && i_addr == 16'h3016 |=> !o_rdata[1])
      else $error("reserved state bit set");
   acq_resv_a: assert property (i_rd && i_addr == 16'h3017 |=> (o_rdata & 8'hE3) == 8'h00)
      else $error("reserved acquisition bits set");
   profile_resv_a: assert property (i_rd && i_addr == 16'h3018 |=> o_rdata[7:6] == 2'h0)
      else $error("reserved profile bits set");
   analog_resv_a: assert property (i_rd && i_addr == 16'h3019 |=> o_rdata[7:5] == 3'h0)
      else $error("reserved analog bits set");
   sticky_bits_a: assert property (i_rd && $past(i_rd) && i_addr == $past(i_addr) && !$past(i_clear_stb)
      |=> (o_rdata & $past(o_rdata)) == $past(o_rdata))
      else $error("event bit dropped without a clear");
   ref_switch_a: assert property (i_rd && i_addr == 16'h3016 && $past(i_ref_switch) && $past(i_resetn)
      |=> o_rdata[7])
      else $error("reference switch not recorded");
   profile_set_a: assert property (i_rd && i_addr == 16'h3018 && $past(i_resetn)
      |=> (o_rdata[5:0] & $past(i_profile_active, 2)) == $past(i_profile_active, 2))
      else $error("profile activation not recorded");
   dist_sync_a: assert property (i_rd && i_addr == 16'h3019 && $past(i_dist_sync) && $past(i_resetn)
      |=> o_rdata[4])
      else $error("distribution sync not recorded");
endmodule

bind lo1_status_bank lo1_status_bank_sva u_sva (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
   .i_rd(i_rd), .o_rdata(o_rdata), .i_clear_stb(i_clear_stb), .i_ref_switch(i_ref_switch),
   .i_profile_active(i_profile_active), .i_dist_sync(i_dist_sync));

// ---- bench/lo1_status_bank_bench.sv ----
// self-checking bench for the channel-one loop event bank
// assumes a 250 MHz clock and read data one cycle after the read strobe
`timescale 1ns/1ns
module lo1_status_bank_bench;
   logic        i_clk = 1'b0;
   logic        i_resetn = 1'b0;
   logic [15:0] i_addr = 16'h0000;
   logic [7:0]  i_wdata = 8'h00;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic        i_clear_stb = 1'b0;
   logic [2:0]  i_clear_index = 3'h0;
   logic [7:0]  i_clear_mask = 8'h00;
   logic [6:0]  lv = 7'h00;
   logic [14:0] pv = 15'h0000;
   logic [7:0]  o_rdata;
   int          bad_count = 0;
   int          n_checks = 0;
   int          cycles = 0;
   // levels: clamp, slew, freq, phase, hitless, analog lock, cal busy
   logic [15:0] lv_addr [7] = '{16'h3015, 16'h3015, 16'h3015, 16'h3015, 16'h3016, 16'h3019, 16'h3019};
   int          lv_rise [7] = '{6, 4, 2, 0, 4, 2, 0};
   int          lv_fall [7] = '{7, 5, 3, 1, 3, 3, 1};
   // pulses: state events, acquisition events, dist sync, profiles 0..5
   logic [15:0] pv_addr [15] = '{16'h3016, 16'h3016, 16'h3016, 16'h3016, 16'h3016, 16'h3017, 16'h3017,
                                 16'h3017, 16'h3019, 16'h3018, 16'h3018, 16'h3018, 16'h3018, 16'h3018, 16'h3018};
   int          pv_bit [15] = '{7, 6, 5, 2, 0, 4, 2, 3, 4, 0, 1, 2, 3, 4, 5};

   lo1_status_bank dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_clear_stb(i_clear_stb),
      .i_clear_index(i_clear_index), .i_clear_mask(i_clear_mask),
      .i_clamp_active(lv[0]), .i_slew_active(lv[1]), .i_freq_locked(lv[2]), .i_phase_locked(lv[3]),
      .i_hitless_active(lv[4]), .i_analog_locked(lv[5]), .i_cal_busy(lv[6]),
      .i_ref_switch(pv[0]), .i_freerun_entered(pv[1]), .i_holdover_entered(pv[2]),
      .i_history_update(pv[3]), .i_phase_step(pv[4]), .i_divider_resync(pv[5]),
      .i_fast_acq_start(pv[6]), .i_fast_acq_done(pv[7]), .i_dist_sync(pv[8]),
      .i_profile_active(pv[14:9]));

   always #2 i_clk = ~i_clk;

   task automatic conclude;
      if (bad_count == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         bad_count++;
         conclude();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         bad_count++;
      end
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge i_clk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      chk(o_rdata, exp);
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask

   // bank index is the offset from the first register
   task automatic clr(input logic [15:0] a);
      @(posedge i_clk);
      i_clear_stb   <= 1'b1;
      i_clear_index <= 3'(a - 16'h3015);
      i_clear_mask  <= 8'hFF;
      @(posedge i_clk);
      i_clear_stb <= 1'b0;
   endtask

   task automatic t_reset;
      for (int a = 16'h3014; a <= 16'h301A; a++) begin
         rd(16'(a), 8'h00);
      end
   endtask

   task automatic t_levels;
      for (int i = 0; i < 7; i++) begin
         @(posedge i_clk);
         lv[i] <= 1'b1;
         rd(lv_addr[i], 8'h01 << lv_rise[i]);
         @(posedge i_clk);
         lv[i] <= 1'b0;
         rd(lv_addr[i], (8'h01 << lv_rise[i]) | (8'h01 << lv_fall[i]));
         clr(lv_addr[i]);
         rd(lv_addr[i], 8'h00);
      end
   endtask

   task automatic t_pulses;
      for (int i = 0; i < 15; i++) begin
         @(posedge i_clk);
         pv[i] <= 1'b1;
         @(posedge i_clk);
         pv[i] <= 1'b0;
         rd(pv_addr[i], 8'h01 << pv_bit[i]);
         repeat (3) @(posedge i_clk);
         rd(pv_addr[i], 8'h01 << pv_bit[i]);
         clr(pv_addr[i]);
         rd(pv_addr[i], 8'h00);
      end
   endtask

   task automatic t_writes;
      @(posedge i_clk);
      pv[3] <= 1'b1;
      @(posedge i_clk);
      pv[3] <= 1'b0;
      for (int a = 16'h3015; a <= 16'h3019; a++) begin
         wr(16'(a), 8'hFF);
         wr(16'(a), 8'h00);
         rd(16'(a), (a == 16'h3016) ? 8'h04 : 8'h00);
      end
      clr(16'h3016);
   endtask

   task automatic t_set_wins;
      @(posedge i_clk);
      pv[3]         <= 1'b1;
      i_clear_stb   <= 1'b1;
      i_clear_index <= 3'h1;
      i_clear_mask  <= 8'hFF;
      @(posedge i_clk);
      pv[3]       <= 1'b0;
      i_clear_stb <= 1'b0;
      rd(16'h3016, 8'h04);
   endtask

   // pulses read in the very next cycle, reads back to back
   task automatic t_burst;
      @(posedge i_clk);
      pv[0] <= 1'b1;
      @(posedge i_clk);
      pv[0]  <= 1'b0;
      pv[8]  <= 1'b1;
      i_rd   <= 1'b1;
      i_addr <= 16'h3016;
      @(posedge i_clk);
      pv[8]    <= 1'b0;
      pv[14:9] <= 6'h2A;
      i_addr   <= 16'h3019;
      #1;
      chk(o_rdata, 8'h80);
      @(posedge i_clk);
      pv[14:9] <= 6'h00;
      i_addr   <= 16'h3018;
      #1;
      chk(o_rdata, 8'h10);
      @(posedge i_clk);
      #1;
      chk(o_rdata, 8'h2A);
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      chk(o_rdata, 8'h2A);
      clr(16'h3016);
      clr(16'h3018);
      clr(16'h3019);
      rd(16'h3018, 8'h00);
   endtask

   // mid-run reset empties the bank; levels standing at release are a baseline
   task automatic t_midreset;
      @(posedge i_clk);
      lv[2] <= 1'b1;
      rd(16'h3015, 8'h04);
      rd(16'h3014, 8'h00);
      rd(16'h301A, 8'h00);
      @(posedge i_clk);
      i_resetn <= 1'b0;
      lv[3]    <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_resetn <= 1'b1;
      rd(16'h3015, 8'h00);
      rd(16'h3016, 8'h00);
      @(posedge i_clk);
      lv[2] <= 1'b0;
      rd(16'h3015, 8'h08);
      // index 5 selects no register
      clr(16'h301A);
      rd(16'h3015, 8'h08);
   endtask

   initial begin
      repeat (2) @(posedge i_clk);
      i_resetn <= 1'b1;
      t_reset();
      t_levels();
      t_pulses();
      t_burst();
      t_writes();
      t_set_wins();
      t_midreset();
      conclude();
   end
endmodule
